// File: dcc_pkg.sv
// constants, types and helpers shared by the display coupler channel block
// assumes bit 0 of every channel word is its most significant bit (2^15)
//
// Notes on behaviour
// - address strobe is pulsed; its rise, while idle with channel-data select set, loads the start address from the output data word.
// - termination lockout set means compare hits and parity errors never end transfers.
// - channel-data select drives the output data word onto the display data lines.
// - pattern write takes left and right byte parity from two control bits.
// - char, bit and double compare each enable early termination while held set.
// - each keyboard strobe latches the output data word into its keyboard register.
// - five-bit field picks group (upper two) and keyboard within group (lower three).
// - selected keyboard mode switches and alert switch read active low.
// - active-low repeat bit shows the selected keyboard repeat key is held.
// - function strobe bit is zero for function codes, one for ascii.
// - seven-bit character field carries the key code in ones complement.
// - parity error status flags a bad word read during input transfer.
// - active-low parity id bits show received byte parity and stay readable.
// - compare status shows a hit on the selected termination condition.
// - key-active bits for 28 keyboards, 1-12 in one word, 13-28 next.
// - word count arrives ones complemented; output stops on count or compare.
// - input transfer stops on count, parity error or compare, whichever first.
// - pattern write repeats the output data word to successive words until count.
// - condition bit is one for count reached, zero for early termination.
// - double compare ends on either end-of-record or end-of-file code.
// - a keyboard strobe sets selected bits and clears all unselected bits.
package dcc_pkg;

   // -----------------------------------------------------------------
   // control word bit positions (bit n of the channel is index 15-n)
   // -----------------------------------------------------------------
   localparam int CW_ADDR_STB = 14;
   localparam int CW_TERM_LOCK = 13;
   localparam int CW_SEL_NC = 12;
   localparam int CW_PAR_L = 11;
   localparam int CW_PAR_R = 10;
   localparam int CW_CMP_CHAR = 9;
   localparam int CW_CMP_BIT = 8;
   localparam int CW_CMP_DBL = 7;
   localparam int CW_STB_KB23 = 6;
   localparam int CW_STB_KB01 = 5;

   // -----------------------------------------------------------------
   // codes, counts and reset values
   // -----------------------------------------------------------------
   localparam logic [1:0] CONNECT_CODE = 2'h2;
   localparam logic [6:0] END_OF_RECORD = 7'h1F;
   localparam logic [6:0] END_OF_FILE = 7'h1C;
   localparam int KBD_COUNT = 28;
   localparam int KBD_PER_GROUP = 7;
   localparam int KBD_IN_ERR_WORD = 12;
   localparam logic ODD_PARITY = 1'b1;
   localparam logic [15:0] WORD_RST = 16'h0000;
   localparam logic [15:0] KIN_IDLE = 16'h3FFF;
   localparam logic [14:0] ADDR_RST = 15'h0000;

   // status word field positions
   localparam int ST_PERR = 15;
   localparam int ST_PID_L = 14;
   localparam int ST_PID_R = 13;
   localparam int ST_CMP = 12;

   typedef enum logic [2:0] {
      DCC_IDLE,
      DCC_OUT,
      DCC_RD,
      DCC_RDW,
      DCC_END
   } dcc_state_t;

   // -----------------------------------------------------------------
   // helpers
   // -----------------------------------------------------------------
   function automatic logic dcc_par(input logic [7:0] b);
      dcc_par = ^b ^ ODD_PARITY;
   endfunction

   function automatic logic dcc_hit(input logic [15:0] w, input logic [15:0] cmp_word,
                                    input logic char_en, input logic bit_en, input logic dbl_en);
      logic c;
      logic d;
      logic b;
      c = (w[6:0] == cmp_word[6:0]) || (w[14:8] == cmp_word[6:0]);
      d = (w[6:0] == END_OF_RECORD) || (w[6:0] == END_OF_FILE) ||
          (w[14:8] == END_OF_RECORD) || (w[14:8] == END_OF_FILE);
      b = |(w & cmp_word);
      dcc_hit = (char_en && c) || (dbl_en && d) || (bit_en && b);
   endfunction

endpackage

// File: dcc_stream_if.sv
// valid/ready word stream between the coupler and its return buffer
// assumes one clock; a word moves when valid and ready are both high
`timescale 1ns/1ns
interface dcc_stream_if #(parameter int W = 16);
   logic valid;
   logic ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

// File: dcc_skid.sv
// small fifo holding words read from display memory on their way to the controller
// assumes one clock and an active-low asynchronous reset
`timescale 1ns/1ns
module dcc_skid #(
   parameter int W = 16,
   parameter int DEPTH = 2
) (
   input wire logic clk,
   input wire logic rst_b,
   dcc_stream_if.snk push,
   dcc_stream_if.src pop
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
   } dcc_skid_t;

   dcc_skid_t s_q;
   dcc_skid_t s_d;
   logic do_push;
   logic do_pop;

   // full and empty come from the count so a stalled reader really fills it
   assign push.ready = (s_q.cnt != (AW+1)'(DEPTH));
   assign pop.valid = (s_q.cnt != '0);
   assign pop.data = s_q.mem[s_q.rp];
   assign do_push = push.valid && push.ready;
   assign do_pop = pop.valid && pop.ready;

   always_comb begin
      s_d = s_q;
      if (do_push) begin
         s_d.mem[s_q.wp] = push.data;
         s_d.wp = (s_q.wp == AW'(DEPTH-1)) ? '0 : s_q.wp + 1'b1;
      end
      if (do_pop) begin
         s_d.rp = (s_q.rp == AW'(DEPTH-1)) ? '0 : s_q.rp + 1'b1;
      end
      s_d.cnt = s_q.cnt + (AW+1)'(do_push) - (AW+1)'(do_pop);
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
endmodule

// File: dcc_kbd_out.sv
// the two keyboard light and buzzer registers, loaded on a strobe's rising edge
// assumes strobe levels come from the control word, synchronous to clk
`timescale 1ns/1ns
module dcc_kbd_out
   import dcc_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic stb01,
   input wire logic stb23,
   input wire logic [15:0] sel_word,
   output logic [15:0] kb01,
   output logic [15:0] kb23
);
   typedef struct packed {
      logic stb01;
      logic stb23;
      logic [15:0] kb01;
      logic [15:0] kb23;
   } dcc_kbo_t;

   dcc_kbo_t s_q;
   dcc_kbo_t s_d;

   always_comb begin
      s_d = s_q;
      s_d.stb01 = stb01;
      s_d.stb23 = stb23;
      if (stb01 && !s_q.stb01) begin
         s_d.kb01 = sel_word;
      end
      if (stb23 && !s_q.stb23) begin
         s_d.kb23 = sel_word;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign kb01 = s_q.kb01;
   assign kb23 = s_q.kb23;
endmodule

// File: dcc_coupler.sv
// display coupler: normal channel control and status, block transfers to display memory
// assumes the controller holds channel words as levels synchronous to clk
`timescale 1ns/1ns
module dcc_coupler
   import dcc_pkg::*;
#(
   parameter int NKBD = KBD_COUNT,
   parameter int BUF_DEPTH = 2
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [15:0] coupler_control_word,
   input wire logic [15:0] output_data_word,
   input wire logic [1:0] connect_code_word,
   input wire logic bt_start,
   input wire logic bt_input,
   input wire logic [15:0] bt_count,
   input wire logic bt_out_valid,
   input wire logic [15:0] bt_out_data,
   output logic bt_out_ready,
   output logic bt_in_valid,
   output logic [15:0] bt_in_data,
   input wire logic bt_in_ready,
   output logic bt_done,
   output logic bt_cond,
   output logic [15:0] keyboard_input_word,
   output logic [15:0] error_and_active_low_word,
   output logic [15:0] active_high_keyboards_word,
   output logic [15:0] kbd_lights_01,
   output logic [15:0] kbd_lights_23,
   output logic [14:0] mem_addr,
   output logic mem_addr_load,
   output logic [15:0] mem_wdata,
   output logic [1:0] mem_wpar,
   output logic mem_we,
   output logic mem_re,
   input wire logic [15:0] mem_rdata,
   input wire logic [1:0] mem_rpar,
   input wire logic mem_rvalid,
   input wire logic [NKBD-1:0][3:0] kbd_mode_b,
   input wire logic [NKBD-1:0] kbd_alert_b,
   input wire logic [NKBD-1:0] repeat_key_b,
   input wire logic [NKBD-1:0] kbd_fn_strobe_b,
   input wire logic [NKBD-1:0][6:0] kbd_char_b,
   input wire logic [NKBD-1:0] kbd_active
);

   // -----------------------------------------------------------------
   // state
   // -----------------------------------------------------------------
   typedef struct packed {
      dcc_state_t st;
      logic [15:0] cnt;
      logic [14:0] addr;
      logic [14:0] maddr;
      logic ald;
      logic [15:0] wdata;
      logic [1:0] wpar;
      logic we;
      logic re;
      logic addr_stb;
      logic done;
      logic cond;
      logic perr;
      logic cmp;
      logic [1:0] pid_b;
      logic out_rdy;
      logic [15:0] kin;
      logic [15:0] err;
      logic [15:0] act;
   } dcc_core_t;

   dcc_core_t s_q;
   dcc_core_t s_d;

   dcc_stream_if #(.W(16)) rd_push ();
   dcc_stream_if #(.W(16)) rd_pop ();

   logic sel_nc;
   logic lockout;
   logic char_en;
   logic bit_en;
   logic dbl_en;
   logic connected;
   logic [1:0] kgrp;
   logic [2:0] kidx;
   logic kvalid;
   int ksel;
   logic [15:0] rd_word;
   logic rd_perr;
   logic rd_hit;
   logic out_hit;
   logic [15:0] cnt_dec;

   // -----------------------------------------------------------------
   // control word decode
   // -----------------------------------------------------------------
   // compare enables are levels
   assign char_en = coupler_control_word[CW_CMP_CHAR];
   assign bit_en = coupler_control_word[CW_CMP_BIT];
   assign dbl_en = coupler_control_word[CW_CMP_DBL];
   assign sel_nc = coupler_control_word[CW_SEL_NC];
   assign lockout = coupler_control_word[CW_TERM_LOCK];
   assign connected = (connect_code_word == CONNECT_CODE);
   assign kgrp = coupler_control_word[4:3];
   assign kidx = coupler_control_word[2:0];
   assign kvalid = (kidx != 3'h0) && (32'(kgrp) * KBD_PER_GROUP + 32'(kidx) <= NKBD);
   assign ksel = kvalid ? (32'(kgrp) * KBD_PER_GROUP + 32'(kidx) - 1) : 0;

   // -----------------------------------------------------------------
   // word checks
   // -----------------------------------------------------------------
   assign rd_word = mem_rdata;
   assign rd_perr = (dcc_par(mem_rdata[15:8]) != mem_rpar[1]) ||
                    (dcc_par(mem_rdata[7:0]) != mem_rpar[0]);
   // compare char held in output data word
   assign rd_hit = dcc_hit(rd_word, output_data_word, char_en, bit_en, dbl_en);
   assign out_hit = dcc_hit(bt_out_data, output_data_word, char_en, bit_en, dbl_en);
   assign cnt_dec = s_q.cnt - 16'h0001;

   // the read fifo push is taken only in the wait state, which was entered with room
   assign rd_push.valid = (s_q.st == DCC_RDW) && mem_rvalid;
   assign rd_push.data = rd_word;

   // -----------------------------------------------------------------
   // next state
   // -----------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      s_d.done = 1'b0;
      s_d.we = 1'b0;
      s_d.re = 1'b0;
      s_d.ald = 1'b0;
      s_d.addr_stb = coupler_control_word[CW_ADDR_STB];

      if (sel_nc) begin
         s_d.wdata = output_data_word;
         s_d.wpar = {coupler_control_word[CW_PAR_L], coupler_control_word[CW_PAR_R]};
      end

      unique case (s_q.st)
         DCC_IDLE: begin
            // address in bits 1 to F
            if (coupler_control_word[CW_ADDR_STB] && !s_q.addr_stb && sel_nc) begin
               s_d.addr = output_data_word[14:0];
               s_d.maddr = output_data_word[14:0];
               s_d.ald = 1'b1;
            end
            if (bt_start && connected) begin
               s_d.cnt = ~bt_count;
               s_d.perr = 1'b0;
               s_d.cmp = 1'b0;
               if (bt_count == 16'hFFFF) begin
                  s_d.st = DCC_END;
                  s_d.cond = 1'b1;
               end else begin
                  s_d.st = bt_input ? DCC_RD : DCC_OUT;
               end
            end
         end

         DCC_OUT: begin
            if (sel_nc) begin
               s_d.we = 1'b1;
               s_d.maddr = s_q.addr;
               s_d.addr = s_q.addr + 15'h0001;
               s_d.cnt = cnt_dec;
               if (cnt_dec == 16'h0000) begin
                  s_d.st = DCC_END;
                  s_d.cond = 1'b1;
               end
            end else if (bt_out_valid && s_q.out_rdy) begin
               s_d.we = 1'b1;
               s_d.wdata = bt_out_data;
               s_d.wpar = {dcc_par(bt_out_data[15:8]), dcc_par(bt_out_data[7:0])};
               s_d.maddr = s_q.addr;
               s_d.addr = s_q.addr + 15'h0001;
               s_d.cnt = cnt_dec;
               if (out_hit) begin
                  s_d.cmp = 1'b1;
               end
               if (cnt_dec == 16'h0000) begin
                  s_d.st = DCC_END;
                  s_d.cond = 1'b1;
               end else if (out_hit && !lockout) begin
                  s_d.st = DCC_END;
                  s_d.cond = 1'b0;
               end
            end
         end

         DCC_RD: begin
            // only one read is in flight, so room seen here still exists on return
            if (rd_push.ready) begin
               s_d.re = 1'b1;
               s_d.maddr = s_q.addr;
               s_d.addr = s_q.addr + 15'h0001;
               s_d.st = DCC_RDW;
            end
         end

         DCC_RDW: begin
            if (mem_rvalid) begin
               s_d.cnt = cnt_dec;
               s_d.pid_b = ~mem_rpar;
               if (rd_perr) begin
                  s_d.perr = 1'b1;
               end
               if (rd_hit) begin
                  s_d.cmp = 1'b1;
               end
               if (cnt_dec == 16'h0000) begin
                  s_d.st = DCC_END;
                  s_d.cond = 1'b1;
               end else if ((rd_perr || rd_hit) && !lockout) begin
                  s_d.st = DCC_END;
                  s_d.cond = 1'b0;
               end else begin
                  s_d.st = DCC_RD;
               end
            end
         end

         DCC_END: begin
            s_d.done = 1'b1;
            s_d.st = DCC_IDLE;
         end
      endcase

      s_d.out_rdy = (s_d.st == DCC_OUT) && !sel_nc;

      // -----------------------------------------------------------------
      // status words
      // -----------------------------------------------------------------
      if (kvalid) begin
         s_d.kin = 16'h0000;
         s_d.kin[13:10] = kbd_mode_b[ksel];
         s_d.kin[9] = kbd_alert_b[ksel];
         s_d.kin[8] = repeat_key_b[ksel];
         s_d.kin[7] = kbd_fn_strobe_b[ksel];
         s_d.kin[6:0] = kbd_char_b[ksel];
      end else begin
         s_d.kin = KIN_IDLE;
      end

      s_d.err = WORD_RST;
      s_d.err[ST_PERR] = s_d.perr;
      s_d.err[ST_PID_L] = s_d.pid_b[1];
      s_d.err[ST_PID_R] = s_d.pid_b[0];
      s_d.err[ST_CMP] = s_d.cmp;
      s_d.act = WORD_RST;
      // keyboard 1 in bit 4, 13 in bit 0 of next word
      for (int i = 0; i < NKBD; i++) begin
         if (i < KBD_IN_ERR_WORD) begin
            s_d.err[KBD_IN_ERR_WORD - 1 - i] = kbd_active[i];
         end else begin
            s_d.act[15 - (i - KBD_IN_ERR_WORD)] = kbd_active[i];
         end
      end
   end

   // -----------------------------------------------------------------
   // registers
   // -----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s_q <= '0;
         s_q.st <= DCC_IDLE;
         s_q.addr <= ADDR_RST;
         s_q.maddr <= ADDR_RST;
         s_q.pid_b <= 2'h3;
         s_q.kin <= KIN_IDLE;
         // parity id reads inactive (high) while in reset
         s_q.err[ST_PID_L] <= 1'b1;
         s_q.err[ST_PID_R] <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // -----------------------------------------------------------------
   // read return buffer and keyboard output registers
   // -----------------------------------------------------------------
   dcc_skid #(
      .W(16),
      .DEPTH(BUF_DEPTH)
   ) u_skid (
      .clk(clk),
      .rst_b(rst_b),
      .push(rd_push),
      .pop(rd_pop)
   );

   assign bt_in_valid = rd_pop.valid;
   assign bt_in_data = rd_pop.data;
   assign rd_pop.ready = bt_in_ready;

   // controller holds data select while strobing
   dcc_kbd_out u_kbd (
      .clk(clk),
      .rst_b(rst_b),
      .stb01(coupler_control_word[CW_STB_KB01]),
      .stb23(coupler_control_word[CW_STB_KB23]),
      .sel_word(output_data_word),
      .kb01(kbd_lights_01),
      .kb23(kbd_lights_23)
   );

   // -----------------------------------------------------------------
   // outputs
   // -----------------------------------------------------------------
   assign bt_out_ready = s_q.out_rdy;
   assign bt_done = s_q.done;
   assign bt_cond = s_q.cond;
   assign keyboard_input_word = s_q.kin;
   assign error_and_active_low_word = s_q.err;
   assign active_high_keyboards_word = s_q.act;
   assign mem_addr = s_q.maddr;
   assign mem_addr_load = s_q.ald;
   assign mem_wdata = s_q.wdata;
   assign mem_wpar = s_q.wpar;
   assign mem_we = s_q.we;
   assign mem_re = s_q.re;
endmodule

// File: dcc_coupler_asserts.sv
// assertions on the display coupler top-level ports
// assumes one clock and an asynchronous active-low reset
`timescale 1ns/1ns
module dcc_coupler_asserts #(parameter int NKBD = 28) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [15:0] coupler_control_word,
   input wire logic [15:0] output_data_word,
   input wire logic bt_out_ready,
   input wire logic bt_done,
   input wire logic bt_cond,
   input wire logic [15:0] keyboard_input_word,
   input wire logic [15:0] error_and_active_low_word,
   input wire logic [15:0] active_high_keyboards_word,
   input wire logic [15:0] kbd_lights_01,
   input wire logic [14:0] mem_addr,
   input wire logic mem_addr_load,
   input wire logic [15:0] mem_wdata,
   input wire logic [1:0] mem_wpar,
   input wire logic mem_we,
   input wire logic [NKBD-1:0] kbd_active
);
   // ------------------------------
   // port relations
   // ------------------------------
   logic [15:0] cw, od, ah;
   assign cw = coupler_control_word;
   assign od = output_data_word;
   assign ah = {<<{kbd_active[27:12]}};
   default clocking dcc_cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   property p_adr; mem_addr_load |-> $past(cw[14]) && mem_addr == $past(od[14:0]); endproperty
   a_adr: assert property (p_adr) else $error("start address not taken from data word");
   property p_k01; $rose(cw[5]) |=> kbd_lights_01 == $past(od); endproperty
   a_k01: assert property (p_k01) else $error("keyboard register not loaded");
   property p_khold; !$rose(cw[5]) |=> $stable(kbd_lights_01); endproperty
   a_khold: assert property (p_khold) else $error("keyboard register changed unstrobed");
   property p_done; bt_done |=> !bt_done; endproperty
   a_done: assert property (p_done) else $error("done longer than one cycle");
   // pattern words come from the data word with the supplied parity
   property p_pat; mem_we && $past(cw[12]) |-> mem_wdata == $past(od) && mem_wpar == $past(cw[11:10]); endproperty
   a_pat: assert property (p_pat) else $error("pattern word or parity wrong");
   property p_step; mem_we && $past(mem_we) |-> mem_addr == $past(mem_addr) + 15'h1; endproperty
   a_step: assert property (p_step) else $error("address did not advance");
   property p_sel; bt_out_ready |-> !$past(cw[12]); endproperty
   a_sel: assert property (p_sel) else $error("channel path open while data select set");
   property p_nokb; cw[2:0] == 3'h0 |=> keyboard_input_word == 16'h3FFF; endproperty
   a_nokb: assert property (p_nokb) else $error("input word not idle with no keyboard");
   property p_act; 1'b1 |=> active_high_keyboards_word == $past(ah); endproperty
   a_act: assert property (p_act) else $error("active keyboard word wrong");
   c_hit: cover property (error_and_active_low_word[12]);
   c_early: cover property (bt_done && !bt_cond);
   c_pat: cover property (mem_we && cw[12]);
endmodule
bind dcc_coupler dcc_coupler_asserts #(.NKBD(NKBD)) dcc_coupler_asserts_inst (.*);

// File: dcc_mem_model.sv
// display memory stand-in answering the coupler's reads and writes
// assumes one read outstanding; bad_addr flips left parity when read
`timescale 1ns/1ns
module dcc_mem_model (
   input wire logic clk,
   input wire logic [14:0] mem_addr,
   input wire logic [15:0] mem_wdata,
   input wire logic [1:0] mem_wpar,
   input wire logic mem_we,
   input wire logic mem_re,
   input wire logic [14:0] bad_addr,
   input wire logic slow,
   output logic [15:0] mem_rdata,
   output logic [1:0] mem_rpar,
   output logic mem_rvalid
);
   // ------------------------------
   // storage and read pipe
   // ------------------------------
   logic [17:0] m [0:63];
   logic [14:0] ra;
   logic [1:0] p = 2'h0;
   logic go;
   assign go = slow ? p[1] : p[0];
   initial {mem_rvalid, mem_rpar, mem_rdata} = '0;
   always @(posedge clk) begin
      p <= {p[0], mem_re};
      if (mem_re) ra <= mem_addr;
      if (mem_we) m[mem_addr[5:0]] <= {mem_wpar, mem_wdata};
      mem_rvalid <= go;
      // stale data is never left standing on the lines
      if (go) {mem_rpar, mem_rdata} <= m[ra[5:0]] ^ {ra == bad_addr, 17'h0};
      else {mem_rpar, mem_rdata} <= ~{mem_rpar, mem_rdata};
   end
endmodule

// File: dcc_coupler_tb.sv
// self-checking bench for the display coupler
// assumes the memory model as far side and the bench as buffer controller
`timescale 1ns/1ns
module dcc_coupler_tb;
   import dcc_pkg::*;
   logic clk, rst_b, bt_start, bt_input, bt_out_valid, bt_in_ready, slow, bt_out_ready, bt_in_valid;
   logic bt_done, bt_cond, mem_addr_load, mem_we, mem_re, mem_rvalid;
   logic [15:0] cw, od, bt_count, bt_out_data, bt_in_data, keyboard_input_word, kbd_lights_01, kbd_lights_23;
   logic [15:0] error_and_active_low_word, active_high_keyboards_word, mem_wdata, mem_rdata;
   logic [14:0] mem_addr, bad_addr;
   logic [1:0] connect_code_word, mem_wpar, mem_rpar;
   logic [27:0][3:0] kbd_mode_b;
   logic [27:0][6:0] kbd_char_b;
   logic [27:0] kbd_alert_b, repeat_key_b, kbd_fn_strobe_b, kbd_active;
   logic [15:0] wr [4];
   logic [15:0] rd [8];
   int bad_count = 0, samples_checked = 0, g;
   dcc_coupler dcc_coupler_inst (.clk, .rst_b, .coupler_control_word(cw), .output_data_word(od),
      .connect_code_word, .bt_start, .bt_input, .bt_count, .bt_out_valid, .bt_out_data, .bt_out_ready,
      .bt_in_valid, .bt_in_data, .bt_in_ready, .bt_done, .bt_cond, .keyboard_input_word,
      .error_and_active_low_word, .active_high_keyboards_word, .kbd_lights_01, .kbd_lights_23, .mem_addr,
      .mem_addr_load, .mem_wdata, .mem_wpar, .mem_we, .mem_re, .mem_rdata, .mem_rpar, .mem_rvalid,
      .kbd_mode_b, .kbd_alert_b, .repeat_key_b, .kbd_fn_strobe_b, .kbd_char_b, .kbd_active);
   dcc_mem_model dcc_mem_model_inst (.clk, .mem_addr, .mem_wdata, .mem_wpar, .mem_we, .mem_re, .bad_addr,
      .slow, .mem_rdata, .mem_rpar, .mem_rvalid);
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // ------------------------------
   // channel tasks
   // ------------------------------
   task automatic chk(input logic [15:0] a, input logic [15:0] e);
      samples_checked++;
      if (a !== e) begin
         bad_count++;
         $display("BAD %0t got %h exp %h", $time, a, e);
      end
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic tick(int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic pulse(int b);
      cw[b] <= 1'b1;
      tick(1);
      cw[b] <= 1'b0;
      tick(2);
   endtask
   task automatic addr(logic [14:0] a, logic keep);
      od <= {1'b0, a};
      cw[12] <= 1'b1;
      tick(1);
      pulse(14);
      cw[12] <= keep;
      tick(1);
      chk(16'(mem_addr), 16'(a));
   endtask
   // valid is held until ready is seen; the receiver stalls every other cycle
   task automatic xfer(logic inp, int n, logic [15:0] o, output int got);
      int k = 0, d = 0;
      got = 0;
      od <= o;
      bt_input <= inp;
      bt_count <= ~16'(n);
      bt_start <= 1'b1;
      tick(1);
      bt_start <= 1'b0;
      for (int t = 0; t < 300 && d < 5; t++) begin
         bt_out_valid <= !inp && k < n && d == 0;
         bt_out_data <= wr[k % 4];
         bt_in_ready <= t[0];
         tick(1);
         if (bt_out_valid && bt_out_ready) k++;
         if (bt_in_valid && bt_in_ready && got < 8) begin
            rd[got] = bt_in_data;
            got++;
         end
         if (bt_done || d > 0) d++;
      end
      bt_out_valid <= 1'b0;
      if (d == 0) begin
         bad_count++;
         $display("BAD %0t transfer never ended", $time);
         test_done();
      end
   endtask
   initial begin
      {cw, od, bt_count, bt_out_data, kbd_active} = '0;
      {rst_b, bt_start, bt_input, bt_out_valid, bt_in_ready, slow} = '0;
      connect_code_word = 2'h2;
      bad_addr = 15'h7FFF;
      for (int i = 0; i < 28; i++) begin
         kbd_mode_b[i] = 4'(i);
         kbd_char_b[i] = 7'(i + 33);
         {kbd_alert_b[i], repeat_key_b[i], kbd_fn_strobe_b[i]} = 3'(i);
      end
      tick(6);
      rst_b <= 1'b1;
      tick(2);
      chk(error_and_active_low_word, 16'h6000);
      kbd_active <= 28'h9A5C3F1;
      for (int s = 0; s < 32; s++) begin
         cw[4:0] <= 5'(s);
         tick(2);
         g = s[4:3] * 7 + s[2:0] - 1;
         chk(keyboard_input_word, (s[2:0] == 0 || g > 27) ? 16'h3FFF : {2'b00, kbd_mode_b[g], kbd_alert_b[g],
            repeat_key_b[g], kbd_fn_strobe_b[g], kbd_char_b[g]});
      end
      chk(active_high_keyboards_word, 16'h3A59);
      chk(error_and_active_low_word[11:0], 12'h8FC);
      cw[12] <= 1'b1;
      for (int j = 0; j < 3; j++) begin
         od <= 16'hA5C3 >> j;
         pulse(5 + j % 2);
         chk(j % 2 ? kbd_lights_23 : kbd_lights_01, 16'hA5C3 >> j);
      end
      chk(kbd_lights_23, 16'h52E1);
      wr = '{16'h1111, 16'h221C, 16'h1111, 16'h1111};
      addr(15'h10, 1'b0);
      xfer(1'b0, 4, 16'h0, g);
      chk(bt_cond, 1'b1);
      addr(15'h10, 1'b0);
      slow <= 1'b1;
      xfer(1'b1, 4, 16'h0, g);
      slow <= 1'b0;
      chk({bt_cond, error_and_active_low_word[15:12]}, 5'h10);
      for (int i = 0; i < 4; i++) chk(rd[i], wr[i]);
      // char, bit and double compare in turn on the returned stream
      for (int m = 0; m < 3; m++) begin
         addr(15'h10, 1'b0);
         cw[9 - m] <= 1'b1;
         xfer(1'b1, 4, m == 0 ? 16'h2222 : m == 1 ? 16'h0200 : 16'h1F1F, g);
         cw[9 - m] <= 1'b0;
         chk({bt_cond, error_and_active_low_word[12]}, 2'h1);
      end
      for (int l = 0; l < 2; l++) begin
         addr(15'h20, 1'b0);
         cw[13] <= l[0];
         cw[9] <= 1'b1;
         xfer(1'b0, 4, 16'h1C1C, g);
         chk(bt_cond, l[0]);
      end
      cw[9] <= 1'b0;
      bad_addr <= 15'h12;
      for (int l = 0; l < 2; l++) begin
         addr(15'h10, 1'b0);
         cw[13] <= l[0];
         xfer(1'b1, 4, 16'h0, g);
         chk({bt_cond, error_and_active_low_word[15:13]}, l ? 4'hC : 4'h6);
      end
      cw[13] <= 1'b0;
      bad_addr <= 15'h7FFF;
      addr(15'h30, 1'b1);
      cw[11:10] <= 2'h2;
      xfer(1'b0, 3, 16'hBEEF, g);
      chk(bt_cond, 1'b1);
      cw[11:10] <= 2'h0;
      addr(15'h30, 1'b0);
      xfer(1'b1, 3, 16'h0, g);
      for (int i = 0; i < 3; i++) chk(rd[i], 16'hBEEF);
      chk(error_and_active_low_word[15:13], 3'h1);
      test_done();
   end
endmodule
